// [logic/cch_map.svh]
// named offsets, codes and counts of the configuration chain hand-off block
`ifndef CCH_MAP_SVH
`define CCH_MAP_SVH

// ----------------------------------------------------------------
// boundary-scan instruction register
// ----------------------------------------------------------------
`define CCH_IR_W 2
`define CCH_IR_BYPASS 2'h3
`define CCH_IR_PROGRAM 2'h1
`define CCH_IR_CAPTURE 2'h1

// ----------------------------------------------------------------
// scheme select codes
// ----------------------------------------------------------------
`define CCH_SCH_JTAG_ONLY 4'h0
`define CCH_SCH_PS 4'h2
`define CCH_SCH_AS 4'h3
`define CCH_SCH_FPP 4'h4

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define CCH_CNT_W 11
`define CCH_BITSTREAM_BITS 11'h100
`define CCH_INIT_TCK 11'h446
`define CCH_FPP_STEP 11'h008
`define CCH_SER_STEP 11'h001
`define CCH_CNT_ONE 11'h001
`define CCH_CNT_ZERO 11'h000
`define CCH_SYNC_W 20

`endif

// [logic/cch_pkg.sv]
// types of the configuration chain hand-off block
package cch_pkg;

	typedef enum logic [3:0] {
		TAP_EXIT2_DR = 4'h0,
		TAP_EXIT1_DR = 4'h1,
		TAP_SHIFT_DR = 4'h2,
		TAP_PAUSE_DR = 4'h3,
		TAP_SEL_IR = 4'h4,
		TAP_UPD_DR = 4'h5,
		TAP_CAP_DR = 4'h6,
		TAP_SEL_DR = 4'h7,
		TAP_EXIT2_IR = 4'h8,
		TAP_EXIT1_IR = 4'h9,
		TAP_SHIFT_IR = 4'hA,
		TAP_PAUSE_IR = 4'hB,
		TAP_IDLE = 4'hC,
		TAP_UPD_IR = 4'hD,
		TAP_CAP_IR = 4'hE,
		TAP_RESET = 4'hF
	} cch_tap_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'h0,
		ST_LOAD = 3'h1,
		ST_INIT = 3'h2,
		ST_WAIT_ALL = 3'h3,
		ST_USER = 3'h4
	} cch_cfg_t;

endpackage

// [logic/cch_sync.sv]
// two-flop synchroniser for the pins of the hand-off block
`timescale 1ns/1ps
`default_nettype none
module cch_sync #(
	parameter int W = 20
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta_q;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta_q[g] <= 1'b0;
					o_q[g] <= 1'b0;
				end else begin
					meta_q[g] <= i_d[g];
					o_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// [logic/cch_handoff.sv]
// configuration chain hand-off: boundary-scan loader, passive loader, shared lines
// What this block does
// - drive chain-enable output low after own configuration
// - shared lines: all enter user mode together
// - scan load in order: output low after load
// - single bypass stage, no device count limit
// - serial input in all passive schemes; parallel only fast
// - release done line at end of configuration
// - bypass passes data through one register stage
// - reconfigure request ignored during scan programming
`timescale 1ns/1ps
`default_nettype none
`include "cch_map.svh"
module cch_handoff import cch_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// boundary-scan pins
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	output logic o_tdo,
	// chain and configuration pins
	input wire logic i_chain_enable_in_n,
	output logic o_chain_enable_out_n,
	input wire logic i_reconfigure_request_n,
	input wire logic [3:0] i_scheme_select,
	input wire logic i_config_clock_pin,
	input wire logic i_serial_config_input,
	input wire logic [6:0] i_parallel_data,
	// shared open-drain lines
	input wire logic i_config_complete_line,
	output logic o_config_complete_line,
	output logic o_config_complete_line_oe_n,
	input wire logic i_config_fault_line,
	output logic o_config_fault_line,
	output logic o_config_fault_line_oe_n,
	// status
	output logic o_user_mode,
	output logic [7:0] o_config_checksum
);

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [`CCH_SYNC_W-1:0] syn;
	logic tck_s, tms_s, tdi_s, chain_in_n_s, reconf_n_s, cclk_s, serial_s, done_s, fault_s;
	logic [3:0] scheme_s;
	logic [6:0] par_s;
	logic tck_prev_q, cclk_prev_q, tck_rise, cclk_rise;

	cch_sync #(.W(`CCH_SYNC_W)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_d({i_tck, i_tms, i_tdi, i_chain_enable_in_n, i_reconfigure_request_n,
			i_scheme_select, i_serial_config_input, i_parallel_data,
			i_config_clock_pin, i_config_complete_line, i_config_fault_line}),
		.o_q(syn)
	);

	assign {tck_s, tms_s, tdi_s, chain_in_n_s, reconf_n_s, scheme_s, serial_s, par_s,
		cclk_s, done_s, fault_s} = syn;
	assign tck_rise = tck_s & ~tck_prev_q;
	assign cclk_rise = cclk_s & ~cclk_prev_q;

	// ----------------------------------------------------------------
	// test access port
	// ----------------------------------------------------------------
	function automatic cch_tap_t tap_next(input cch_tap_t s, input logic tms);
		unique case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction

	cch_tap_t tap_q, tap_d;
	logic [`CCH_IR_W-1:0] ir_q, ir_d, irsh_q, irsh_d;
	logic byp_q, byp_d, tdo_q, tdo_d;

	always_comb begin
		tap_d = tap_q;
		ir_d = ir_q;
		irsh_d = irsh_q;
		byp_d = byp_q;
		tdo_d = tdo_q;
		if (tck_rise) begin
			tap_d = tap_next(tap_q, tms_s);
			if (tap_q == TAP_RESET) begin
				ir_d = `CCH_IR_BYPASS;
			end else if (tap_q == TAP_CAP_IR) begin
				irsh_d = `CCH_IR_CAPTURE;
			end else if (tap_q == TAP_SHIFT_IR) begin
				irsh_d = {tdi_s, irsh_q[`CCH_IR_W-1:1]};
				tdo_d = irsh_q[0];
			end else if (tap_q == TAP_UPD_IR) begin
				ir_d = irsh_q;
			end else if (tap_q == TAP_CAP_DR) begin
				byp_d = 1'b0;
			end else if (tap_q == TAP_SHIFT_DR) begin
				// one stage per device keeps any chain length usable
				// tdo mirrors the bypass stage so the host sees each bit one tck later
				byp_d = tdi_s;
				tdo_d = tdi_s;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tap_q <= TAP_RESET;
			ir_q <= `CCH_IR_BYPASS;
			irsh_q <= `CCH_IR_CAPTURE;
			byp_q <= 1'b0;
			tdo_q <= 1'b0;
			tck_prev_q <= 1'b0;
			cclk_prev_q <= 1'b0;
		end else begin
			tap_q <= tap_d;
			ir_q <= ir_d;
			irsh_q <= irsh_d;
			byp_q <= byp_d;
			tdo_q <= tdo_d;
			tck_prev_q <= tck_s;
			cclk_prev_q <= cclk_s;
		end
	end

	assign o_tdo = tdo_q;

	// ----------------------------------------------------------------
	// configuration sequence
	// ----------------------------------------------------------------
	cch_cfg_t st_q, st_d;
	logic jtag_q, jtag_d, chain_out_n_q, chain_out_n_d, done_oe_n_q, done_oe_n_d;
	logic fault_oe_n_q, fault_oe_n_d, user_q, user_d;
	logic [`CCH_CNT_W-1:0] cnt_q, cnt_d, step;
	logic [7:0] chk_q, chk_d, word;
	logic scan_only, fast_passive_parallel_scheme, prog_start, load_edge, init_edge;

	assign scan_only = (scheme_s == `CCH_SCH_JTAG_ONLY);
	assign fast_passive_parallel_scheme = (scheme_s == `CCH_SCH_FPP);
	assign prog_start = tck_rise && (tap_q == TAP_UPD_IR) && (irsh_q == `CCH_IR_PROGRAM)
		&& !chain_in_n_s;
	assign load_edge = jtag_q ? (tck_rise && tap_q == TAP_SHIFT_DR && ir_q == `CCH_IR_PROGRAM)
		: cclk_rise;
	assign init_edge = jtag_q ? tck_rise : cclk_rise;
	// the upper data lanes count only in the fast parallel scheme
	assign step = (!jtag_q && fast_passive_parallel_scheme) ? `CCH_FPP_STEP : `CCH_SER_STEP;
	assign word = jtag_q ? {7'h00, tdi_s} : (fast_passive_parallel_scheme ? {par_s, serial_s} : {7'h00, serial_s});

	always_comb begin
		st_d = st_q;
		jtag_d = jtag_q;
		cnt_d = cnt_q;
		chk_d = chk_q;
		fault_oe_n_d = 1'b1;
		if (prog_start) begin
			st_d = ST_LOAD;
			jtag_d = 1'b1;
			cnt_d = `CCH_CNT_ZERO;
			chk_d = 8'h00;
		end else if (!jtag_q && !scan_only && !reconf_n_s) begin
			// request only acts outside scan programming
			st_d = ST_WAIT;
			cnt_d = `CCH_CNT_ZERO;
			fault_oe_n_d = 1'b0;
		end else begin
			unique case (st_q)
				ST_WAIT: begin
					if (!scan_only && reconf_n_s && !chain_in_n_s) begin
						st_d = ST_LOAD;
						jtag_d = 1'b0;
						cnt_d = `CCH_CNT_ZERO;
						chk_d = 8'h00;
					end
				end
				ST_LOAD: begin
					if (load_edge) begin
						chk_d = chk_q ^ word;
						cnt_d = cnt_q + step;
						if (cnt_q + step >= `CCH_BITSTREAM_BITS) begin
							st_d = ST_INIT;
							cnt_d = `CCH_CNT_ZERO;
						end
					end
				end
				ST_INIT: begin
					if (init_edge) begin
						cnt_d = cnt_q + `CCH_CNT_ONE;
						if (cnt_q + `CCH_CNT_ONE == `CCH_INIT_TCK) begin
							st_d = ST_WAIT_ALL;
						end
					end
				end
				ST_WAIT_ALL: begin
					// wired-AND level high means every device has finished
					if (done_s && fault_s) begin
						st_d = ST_USER;
					end
				end
				ST_USER: begin
					st_d = ST_USER;
				end
				default: begin
					st_d = ST_WAIT;
				end
			endcase
		end
		chain_out_n_d = !(st_d == ST_WAIT_ALL || st_d == ST_USER);
		// open-drain: pull low until loaded, then let the pull-up raise it
		done_oe_n_d = (st_d == ST_WAIT_ALL || st_d == ST_USER);
		user_d = (st_d == ST_USER);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= ST_WAIT;
			jtag_q <= 1'b0;
			cnt_q <= `CCH_CNT_ZERO;
			chk_q <= 8'h00;
			chain_out_n_q <= 1'b1;
			done_oe_n_q <= 1'b0;
			fault_oe_n_q <= 1'b1;
			user_q <= 1'b0;
			o_config_complete_line <= 1'b0;
			o_config_fault_line <= 1'b0;
		end else begin
			st_q <= st_d;
			jtag_q <= jtag_d;
			cnt_q <= cnt_d;
			chk_q <= chk_d;
			chain_out_n_q <= chain_out_n_d;
			done_oe_n_q <= done_oe_n_d;
			fault_oe_n_q <= fault_oe_n_d;
			user_q <= user_d;
			o_config_complete_line <= 1'b0;
			o_config_fault_line <= 1'b0;
		end
	end

	assign o_chain_enable_out_n = chain_out_n_q;
	assign o_config_complete_line_oe_n = done_oe_n_q;
	assign o_config_fault_line_oe_n = fault_oe_n_q;
	assign o_user_mode = user_q;
	assign o_config_checksum = chk_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_CHAIN_OUT_LOW: assert property (
		(st_q == ST_INIT && st_d == ST_WAIT_ALL) |=> !o_chain_enable_out_n)
		else $error("chain enable output not low after load");
	AST_CHAIN_OUT_HIGH: assert property (
		(st_q == ST_WAIT || st_q == ST_LOAD || st_q == ST_INIT) |-> o_chain_enable_out_n)
		else $error("chain enable output low before load finished");
	AST_USER_TOGETHER: assert property (
		(st_q == ST_WAIT_ALL && done_s && fault_s && !prog_start
			&& !(!jtag_q && !scan_only && !reconf_n_s)) |=> o_user_mode)
		else $error("user mode not entered on shared done");
	AST_USER_NEEDS_LINE: assert property (
		$rose(o_user_mode) |-> $past(done_s) && $past(fault_s))
		else $error("user mode without shared lines high");
	AST_DONE_RELEASED: assert property (
		(st_q == ST_WAIT_ALL) |-> o_config_complete_line_oe_n && !o_config_complete_line)
		else $error("done line still held after load");
	AST_BYPASS_ONE_STAGE: assert property (
		(tck_rise && tap_q == TAP_SHIFT_DR) |=> o_tdo == $past(tdi_s) && byp_q == $past(tdi_s))
		else $error("bypass delay wrong");
	AST_RECONF_IGNORED: assert property (
		(jtag_q && st_q == ST_LOAD && !reconf_n_s) |=> st_q != ST_WAIT)
		else $error("request acted during scan programming");
	AST_RECONF_RESETS: assert property (
		(!jtag_q && !scan_only && !reconf_n_s && !prog_start)
			|=> st_q == ST_WAIT && !o_config_fault_line_oe_n)
		else $error("request low did not restart passive load");
	AST_FPP_STEP: assert property (
		(st_q == ST_LOAD && !jtag_q && fast_passive_parallel_scheme && cclk_rise && reconf_n_s && !prog_start
			&& cnt_q + `CCH_FPP_STEP < `CCH_BITSTREAM_BITS)
			|=> cnt_q == $past(cnt_q) + `CCH_FPP_STEP)
		else $error("fast parallel step not eight bits");
	AST_TDO_SHIFT: assert property (
		!tck_rise |=> $stable(o_tdo))
		else $error("scan output moved without a test clock edge");

	COV_SCAN_USER: cover property (jtag_q && $rose(o_user_mode));
	COV_PASSIVE_USER: cover property (!jtag_q && $rose(o_user_mode));
	COV_WAIT_OTHERS: cover property (st_q == ST_WAIT_ALL && !done_s);

endmodule
`default_nettype wire

// [verification/cch_host_model.sv]
// scan host model that drives the boundary-scan pins of the hand-off block
`timescale 1ns/1ps
`default_nettype none
`include "cch_map.svh"
module cch_host_model (
	// scan pins
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	// ----
	// tap stepping
	// ----
	// tck stands low between frames; tms and tdi move only while tck is low
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	task automatic step(input logic tms, input logic tdi);
		o_tms = tms;
		o_tdi = tdi;
		#32 o_tck = 1'b1;
		#32 o_tck = 1'b0;
	endtask
	task automatic tap_reset();
		repeat (5) step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	// idle to idle, two instruction bits lsb first
	task automatic load_ir(input logic [1:0] code);
		step(1'b1, 1'b0);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, code[0]);
		step(1'b1, code[1]);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic enter_dr();
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
	endtask
	// whole image goes to this one device before init, even with private lines
	task automatic init_clocks();
		repeat (`CCH_INIT_TCK) step(1'b0, 1'b0);
	endtask
endmodule
`default_nettype wire

// [verification/cch_handoff_tb.sv]
// self-checking bench of the configuration chain hand-off block
`timescale 1ns/1ps
`default_nettype none
`include "cch_map.svh"
module cch_handoff_tb;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic tck, tms, tdi, tdo, chain_out_n, user, done_oe_n, done_o, fault_oe_n, fault_o;
	logic chain_in_n = 1'b1;
	logic req_n = 1'b1;
	logic cfg_pin = 1'b0;
	logic ser_in = 1'b0;
	logic other_done = 1'b0;
	logic [3:0] scheme = `CCH_SCH_JTAG_ONLY;
	logic [6:0] par = 7'h00;
	logic [1:0] prev;
	logic bit_v;
	logic [7:0] chk;
	logic [7:0] exp_chk = 8'h00;
	int load_left = 0;
	logic [3:0] sch[3] = '{`CCH_SCH_PS, `CCH_SCH_AS, `CCH_SCH_FPP};
	logic [7:0] exp_res[$];
	logic exp_tdo[$];
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int edges;
	wire logic done_line;
	wire logic fault_line;
	// open-drain lines with pull-ups; the other chain member may hold done low
	assign done_line = (done_oe_n | done_o) & other_done;
	assign fault_line = fault_oe_n | fault_o;

	cch_host_model cch_host_model_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	cch_handoff cch_handoff_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .o_tdo(tdo), .i_chain_enable_in_n(chain_in_n),
		.o_chain_enable_out_n(chain_out_n), .i_reconfigure_request_n(req_n),
		.i_scheme_select(scheme), .i_config_clock_pin(cfg_pin),
		.i_serial_config_input(ser_in), .i_parallel_data(par),
		.i_config_complete_line(done_line), .o_config_complete_line(done_o),
		.o_config_complete_line_oe_n(done_oe_n), .i_config_fault_line(fault_line),
		.o_config_fault_line(fault_o), .o_config_fault_line_oe_n(fault_oe_n),
		.o_user_mode(user), .o_config_checksum(chk));

	initial begin
		forever #4 i_clk = ~i_clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----
	// watchers
	// ----
	always @(posedge i_clk) begin
		prev <= {chain_out_n, user};
		if (i_rst_n && prev !== {chain_out_n, user}) begin
			check("chain_out_n,user", {6'h00, chain_out_n, user},
				(exp_res.size() > 0) ? exp_res.pop_front() : 8'hFF);
		end
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			final_report();
		end
	end
	always @(posedge tck) begin
		if (exp_tdo.size() > 0) begin
			check("tdo", {7'h00, tdo}, {7'h00, exp_tdo.pop_front()});
		end
	end

	// ----
	// drivers
	// ----
	task automatic do_reset();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (6) @(posedge i_clk);
	endtask
	task automatic wait_chain(input int limit);
		int n;
		n = 0;
		while (chain_out_n !== 1'b0 && n < limit) begin
			@(posedge i_clk);
			n++;
		end
		repeat (8) @(posedge i_clk);
	endtask
	// tck phase is kept 3 ns off the system clock
	task automatic scan_program();
		#3;
		exp_chk = 8'h00;
		cch_host_model_i.load_ir(`CCH_IR_PROGRAM);
		cch_host_model_i.enter_dr();
		for (int i = 0; i < `CCH_BITSTREAM_BITS; i++) begin
			bit_v = 1'($urandom);
			exp_chk = exp_chk ^ {7'h00, bit_v};
			cch_host_model_i.step(i == `CCH_BITSTREAM_BITS - 1, bit_v);
		end
		cch_host_model_i.step(1'b1, 1'b0);
		cch_host_model_i.step(1'b0, 1'b0);
		cch_host_model_i.init_clocks();
	endtask
	task automatic cfg_edges(input int n);
		repeat (n) begin
			@(posedge i_clk);
			// only the load part of the run feeds the checksum
			if (load_left > 0) begin
				exp_chk = exp_chk ^ ((scheme == `CCH_SCH_FPP) ? {par, ser_in} : {7'h00, ser_in});
				load_left--;
			end
			cfg_pin <= 1'b1;
			repeat (2) @(posedge i_clk);
			cfg_pin <= 1'b0;
			ser_in <= 1'($urandom);
			par <= 7'($urandom);
			@(posedge i_clk);
		end
	endtask

	initial begin
		void'($urandom(75651));
		do_reset();
		check("done_oe_n", {7'h00, done_oe_n}, 8'h00);
		check("fault_oe_n", {7'h00, fault_oe_n}, 8'h01);
		// program instruction refused while the chain input is high
		#3;
		cch_host_model_i.tap_reset();
		scan_program();
		check("chain_out_n", {7'h00, chain_out_n}, 8'h01);
		check("checksum", chk, 8'h00);
		// chain input grounded; a low request must not stop the scan load
		@(posedge i_clk);
		chain_in_n <= 1'b0;
		req_n <= 1'b0;
		exp_res.push_back(8'h00);
		scan_program();
		wait_chain(200);
		check("checksum", chk, exp_chk);
		check("done_oe_n", {7'h00, done_oe_n}, 8'h01);
		check("user", {7'h00, user}, 8'h00);
		exp_res.push_back(8'h01);
		req_n <= 1'b1;
		other_done <= 1'b1;
		repeat (8) @(posedge i_clk);
		// bypass: each bit comes back one tck later
		#3;
		cch_host_model_i.load_ir(`CCH_IR_BYPASS);
		cch_host_model_i.enter_dr();
		for (int i = 0; i < 16; i++) begin
			bit_v = 1'($urandom);
			cch_host_model_i.step(i == 15, bit_v);
			exp_tdo.push_back(bit_v);
		end
		cch_host_model_i.step(1'b1, 1'b0);
		cch_host_model_i.step(1'b0, 1'b0);
		// passive schemes; fault line pulled while the request is low
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			scheme <= sch[k];
			req_n <= 1'b0;
			do_reset();
			check("fault_oe_n", {7'h00, fault_oe_n}, 8'h00);
			exp_res.push_back(8'h00);
			exp_res.push_back(8'h01);
			req_n <= 1'b1;
			repeat (6) @(posedge i_clk);
			edges = (sch[k] == `CCH_SCH_FPP) ? 256 / 8 : 256;
			exp_chk = 8'h00;
			load_left = edges;
			cfg_edges(edges + `CCH_INIT_TCK - 1);
			repeat (4) @(posedge i_clk);
			check("chain_out_n", {7'h00, chain_out_n}, 8'h01);
			cfg_edges(1);
			wait_chain(100);
			check("checksum", chk, exp_chk);
			check("fault_oe_n", {7'h00, fault_oe_n}, 8'h01);
		end
		repeat (10) @(posedge i_clk);
		check("pending", 8'(exp_res.size()), 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
